//--- logic/sdpz_pkg.sv
package sdpz_pkg;
  // ****************************************************
  // Timing figures, in nanoseconds and in cycles
  // ****************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int TCKE_NS = 5;
  localparam int TCPDED_CYC = 1;
  localparam int TXP_NS = 6;
  localparam int TXPDLL_NS = 24;
  localparam int TRFC_NS = 160;
  localparam int TZQINIT_CYC = 512;
  localparam int TZQOPER_CYC = 256;
  localparam int TZQCS_CYC = 64;
  localparam int TCKE_CYC = (TCKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TXP_CYC = (TXP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TXPDLL_CYC = (TXPDLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRFC_CYC = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;

  // ****************************************************
  // Command codes {csN, rasN, casN, weN}
  // ****************************************************
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ZQ = 4'h6;

  // ****************************************************
  // Power state
  // ****************************************************
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_IDLE = 3'b001,
    ST_PD_PRE = 3'b010,
    ST_PD_ACT = 3'b011,
    ST_EXIT = 3'b100,
    ST_ZQ = 3'b101
  } sdpz_state_e;
endpackage

//--- logic/sdpz_timer.sv
`timescale 1ns/100ps
`default_nettype none
module sdpz_timer #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  // Status
  output logic done
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // Down counter, reloads on request
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = loadValue;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign done = (count_reg == '0);
endmodule
`default_nettype wire

//--- logic/sdpz_power_zq.sv
`timescale 1ns/100ps
`default_nettype none
module sdpz_power_zq #(
  parameter int BANKS = 8,
  parameter int ZQ_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Memory pins, from outside the clock domain
  input wire logic ckePin,
  input wire logic dramResetPin_n,
  input wire logic [3:0] cmdPin,
  input wire logic a10Pin,
  input wire logic [2:0] bankPin,
  // Internal status from core
  input wire logic bankBusy,
  input wire logic dllLocked,
  input wire logic preDllSelect,
  input wire logic [ZQ_W-1:0] zqResult,
  // Status
  output logic inPowerDown,
  output logic activePd,
  output logic bufEnable,
  output logic cmdRxEnable,
  output logic dllEnable,
  output logic cmdAllowed,
  output logic dllCmdAllowed,
  output logic zqBusy,
  output logic [ZQ_W-1:0] driverCode,
  output logic dramInReset
);
  // ****************************************************
  // Input synchronisers
  // ****************************************************
  logic [1:0] ckeSync_reg;
  logic [1:0] rstSync_reg;
  logic [3:0] cmdMeta_reg;
  logic [3:0] cmdSync_reg;
  logic [3:0] addrMeta_reg;
  logic [3:0] addrSync_reg;

  // Two flops on every pin
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ckeSync_reg <= 2'h0;
      rstSync_reg <= 2'h0;
      cmdMeta_reg <= sdpz_pkg::CMD_NOP;
      cmdSync_reg <= sdpz_pkg::CMD_NOP;
      addrMeta_reg <= 4'h0;
      addrSync_reg <= 4'h0;
    end else begin
      ckeSync_reg <= {ckeSync_reg[0], ckePin};
      rstSync_reg <= {rstSync_reg[0], dramResetPin_n};
      cmdMeta_reg <= cmdPin;
      cmdSync_reg <= cmdMeta_reg;
      addrMeta_reg <= {a10Pin, bankPin};
      addrSync_reg <= addrMeta_reg;
    end
  end

  logic cke;
  logic dramRst_n;
  logic isNop;
  assign cke = ckeSync_reg[1];
  assign dramRst_n = rstSync_reg[1];
  assign isNop = (cmdSync_reg == sdpz_pkg::CMD_NOP) || (cmdSync_reg[3] == 1'b1);

  // ****************************************************
  // Bank tracking
  // ****************************************************
  logic [BANKS-1:0] open_reg;
  logic [BANKS-1:0] open_next;

  // Activate opens, precharge closes one or all
  always_comb begin
    open_next = open_reg;
    if (cke && (cmdSync_reg == sdpz_pkg::CMD_ACT)) begin
      open_next[addrSync_reg[2:0]] = 1'b1;
    end else if (cke && (cmdSync_reg == sdpz_pkg::CMD_PRE)) begin
      if (addrSync_reg[3]) begin
        open_next = '0;
      end else begin
        open_next[addrSync_reg[2:0]] = 1'b0;
      end
    end
  end

  // ****************************************************
  // Power and calibration state
  // ****************************************************
  sdpz_pkg::sdpz_state_e state_reg;
  sdpz_pkg::sdpz_state_e state_next;
  logic zqFirst_reg;
  logic zqFirst_next;
  logic slowExit_reg;
  logic slowExit_next;
  logic pendPd_reg;
  logic pendPd_next;
  logic [ZQ_W-1:0] code_reg;
  logic [ZQ_W-1:0] code_next;
  logic cpdDone_reg;
  logic cpdDone_next;
  logic tmrLoad;
  logic [sdpz_pkg::CNT_W-1:0] tmrValue;
  logic tmrDone;
  logic dllTmrLoad;
  logic dllTmrDone;

  sdpz_timer #(.W(sdpz_pkg::CNT_W)) mainTimer (
    .clk(clk),
    .reset_n(reset_n),
    .load(tmrLoad),
    .loadValue(tmrValue),
    .done(tmrDone)
  );

  sdpz_timer #(.W(sdpz_pkg::CNT_W)) dllTimer (
    .clk(clk),
    .reset_n(reset_n),
    .load(dllTmrLoad),
    .loadValue(sdpz_pkg::CNT_W'(sdpz_pkg::TXPDLL_CYC)),
    .done(dllTmrDone)
  );

  // Next state
  always_comb begin
    state_next = state_reg;
    zqFirst_next = zqFirst_reg;
    slowExit_next = slowExit_reg;
    pendPd_next = pendPd_reg;
    code_next = code_reg;
    cpdDone_next = cpdDone_reg;
    tmrLoad = 1'b0;
    tmrValue = '0;
    dllTmrLoad = 1'b0;
    if (!dramRst_n) begin
      state_next = sdpz_pkg::ST_RESET;
      zqFirst_next = 1'b1;
      pendPd_next = 1'b0;
    end else begin
      case (state_reg)
        sdpz_pkg::ST_RESET: begin
          state_next = sdpz_pkg::ST_IDLE;
        end
        sdpz_pkg::ST_IDLE: begin
          if (!cke && isNop) begin
            // Entry waits for row, precharge or refresh work
            pendPd_next = 1'b1;
            cpdDone_next = 1'b0;
            tmrLoad = 1'b1;
            tmrValue = sdpz_pkg::CNT_W'(sdpz_pkg::TCPDED_CYC);
          end
          if (pendPd_reg && !bankBusy) begin
            pendPd_next = 1'b0;
            // Bank state picks the power-down kind
            if (open_reg != '0) begin
              state_next = sdpz_pkg::ST_PD_ACT;
              slowExit_next = 1'b0;
            end else begin
              state_next = sdpz_pkg::ST_PD_PRE;
              slowExit_next = !preDllSelect;
            end
          end else if (cke && cmdSync_reg == sdpz_pkg::CMD_ZQ && !pendPd_reg) begin
            state_next = sdpz_pkg::ST_ZQ;
            tmrLoad = 1'b1;
            if (!addrSync_reg[3]) begin
              tmrValue = sdpz_pkg::CNT_W'(sdpz_pkg::TZQCS_CYC);
            end else if (zqFirst_reg) begin
              tmrValue = sdpz_pkg::CNT_W'(sdpz_pkg::TZQINIT_CYC);
              zqFirst_next = 1'b0;
            end else begin
              tmrValue = sdpz_pkg::CNT_W'(sdpz_pkg::TZQOPER_CYC);
            end
          end
        end
        sdpz_pkg::ST_PD_PRE, sdpz_pkg::ST_PD_ACT: begin
          if (tmrDone) begin
            cpdDone_next = 1'b1;
          end
          if (cke && isNop) begin
            // Exit, latency counted from this edge
            state_next = sdpz_pkg::ST_EXIT;
            tmrLoad = 1'b1;
            tmrValue = sdpz_pkg::CNT_W'(sdpz_pkg::TXP_CYC);
            dllTmrLoad = 1'b1;
          end
        end
        sdpz_pkg::ST_EXIT: begin
          if (tmrDone) begin
            state_next = sdpz_pkg::ST_IDLE;
          end
        end
        sdpz_pkg::ST_ZQ: begin
          if (tmrDone) begin
            // Result moves to the driver code
            code_next = zqResult;
            state_next = sdpz_pkg::ST_IDLE;
          end
        end
        default: begin
          state_next = sdpz_pkg::ST_RESET;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= sdpz_pkg::ST_RESET;
      open_reg <= '0;
      zqFirst_reg <= 1'b1;
      slowExit_reg <= 1'b0;
      pendPd_reg <= 1'b0;
      code_reg <= '0;
      cpdDone_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      open_reg <= (state_next == sdpz_pkg::ST_RESET) ? '0 : open_next;
      zqFirst_reg <= zqFirst_next;
      slowExit_reg <= slowExit_next;
      pendPd_reg <= pendPd_next;
      code_reg <= code_next;
      cpdDone_reg <= cpdDone_next;
    end
  end

  // ****************************************************
  // Registered outputs
  // ****************************************************
  logic pdNext;
  logic cmdOkNext;
  assign pdNext = (state_next == sdpz_pkg::ST_PD_PRE) || (state_next == sdpz_pkg::ST_PD_ACT);
  assign cmdOkNext = (state_next == sdpz_pkg::ST_IDLE) && !pendPd_next;

  // Output flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      inPowerDown <= 1'b0;
      activePd <= 1'b0;
      bufEnable <= 1'b1;
      cmdRxEnable <= 1'b1;
      dllEnable <= 1'b1;
      cmdAllowed <= 1'b0;
      dllCmdAllowed <= 1'b0;
      zqBusy <= 1'b0;
      driverCode <= '0;
      dramInReset <= 1'b1;
    end else begin
      inPowerDown <= pdNext;
      activePd <= state_next == sdpz_pkg::ST_PD_ACT;
      bufEnable <= !pdNext;
      cmdRxEnable <= !(pdNext && cpdDone_next);
      dllEnable <= !(pdNext && slowExit_next);
      cmdAllowed <= cmdOkNext;
      dllCmdAllowed <= cmdOkNext && (!slowExit_reg || dllTmrDone) && dllLocked;
      zqBusy <= state_next == sdpz_pkg::ST_ZQ;
      driverCode <= code_next;
      dramInReset <= state_next == sdpz_pkg::ST_RESET;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  pd_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == sdpz_pkg::ST_IDLE && pendPd_reg && !bankBusy && dramRst_n) |=> inPowerDown)
    else $error("power-down not entered");
  pd_kind_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == sdpz_pkg::ST_PD_ACT) |-> (open_reg != '0))
    else $error("active power-down with all banks closed");
  busy_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == sdpz_pkg::ST_IDLE && pendPd_reg && bankBusy && dramRst_n) |=> !inPowerDown)
    else $error("power-down before operation finished");
  buf_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    inPowerDown |-> !bufEnable)
    else $error("buffers on in power-down");
  dll_fast_a: assert property (@(posedge clk) disable iff (!reset_n)
    activePd |-> dllEnable)
    else $error("DLL off in active power-down");
  reset_exit_a: assert property (@(posedge clk) disable iff (!reset_n)
    (inPowerDown && !dramRst_n) |=> dramInReset && !inPowerDown)
    else $error("reset did not leave power-down");
  exit_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == sdpz_pkg::ST_PD_PRE && cke && isNop && dramRst_n) |=> !cmdAllowed [*2])
    else $error("command allowed before tXP");
  zqcs_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == sdpz_pkg::ST_IDLE && cke && cmdSync_reg == sdpz_pkg::CMD_ZQ && !addrSync_reg[3]
     && !pendPd_reg && dramRst_n && !(pendPd_reg && !bankBusy)) |=> ##60 zqBusy)
    else $error("short calibration ended early");
  pd_cov_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(activePd));
  pre_cov_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(inPowerDown) && !dllEnable);
  zq_cov_c: cover property (@(posedge clk) disable iff (!reset_n) $fell(zqBusy));
endmodule
`default_nettype wire

//--- dv/sdpz_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sdpz_ctrl_model (
  // Link clock
  output logic ck,
  // Pins toward the device
  output logic ckePin,
  output logic dramResetPin_n,
  output logic [3:0] cmdPin,
  output logic a10Pin,
  output logic [2:0] bankPin
);
  logic holdAddr;
  // Free-running link clock, kept stable in power-down
  initial begin
    ck = 1'b0;
    #4; // Edges line up with core edges, so pins move 1 ns after one
    forever #32 ck = ~ck;
  end
  // Quiet bus at start: reset high, clock enabled, no operation
  initial begin
    holdAddr = 1'b0;
    ckePin = 1'b1;
    dramResetPin_n = 1'b1;
    cmdPin = sdpz_pkg::CMD_NOP;
    a10Pin = 1'b0;
    bankPin = 3'h0;
  end
  // Address lines are don't-care outside commands, so they keep moving
  always @(negedge ck) begin
    if (!holdAddr) begin
      a10Pin <= ~a10Pin;
      bankPin <= ~bankPin;
    end
  end
  // One command for one link cycle, then no operation
  task automatic issue(input logic [3:0] cmd, input logic a10, input logic [2:0] bank);
    @(posedge ck);
    #1;
    holdAddr = 1'b1;
    cmdPin = cmd;
    a10Pin = a10;
    bankPin = bank;
    @(posedge ck);
    #1;
    cmdPin = sdpz_pkg::CMD_NOP;
    holdAddr = 1'b0;
  endtask
  // CKE change with no operation on that edge and after it
  task automatic setCke(input logic v);
    @(posedge ck);
    #1;
    cmdPin = sdpz_pkg::CMD_NOP;
    ckePin = v;
    repeat (3) @(posedge ck);
    #1;
  endtask
  // Device reset pin, held high otherwise
  task automatic setReset(input logic v);
    @(posedge ck);
    #1;
    dramResetPin_n = v;
    repeat (2) @(posedge ck);
    #1;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_sdpz_power_zq.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sdpz_power_zq;
  // ****
  // Signals
  // ****
  typedef struct {
    logic [5:0] flags;
    logic [7:0] code;
  } sdpz_exp_s;
  logic clk, reset_n, ck, ckePin, dramResetPin_n, a10Pin, bankBusy, dllLocked, preDllSelect;
  logic [3:0] cmdPin;
  logic [2:0] bankPin, prevOut;
  logic [7:0] zqResult, driverCode, codeExp;
  logic inPowerDown, activePd, bufEnable, cmdRxEnable, dllEnable, cmdAllowed, dllCmdAllowed, zqBusy, dramInReset;
  int n_errors, cmp_count, cycles, zqRun, zqLast, tExit, tCmd, tDll, n;
  sdpz_exp_s expQ[$];
  sdpz_exp_s got;

  // Core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Far-side controller
  sdpz_ctrl_model ctrl_u (.ck(ck), .ckePin(ckePin), .dramResetPin_n(dramResetPin_n), .cmdPin(cmdPin),
    .a10Pin(a10Pin), .bankPin(bankPin));
  // Device block
  sdpz_power_zq dut_u (.clk(clk), .reset_n(reset_n), .ckePin(ckePin), .dramResetPin_n(dramResetPin_n),
    .cmdPin(cmdPin), .a10Pin(a10Pin), .bankPin(bankPin), .bankBusy(bankBusy), .dllLocked(dllLocked),
    .preDllSelect(preDllSelect), .zqResult(zqResult), .inPowerDown(inPowerDown), .activePd(activePd),
    .bufEnable(bufEnable), .cmdRxEnable(cmdRxEnable), .dllEnable(dllEnable), .cmdAllowed(cmdAllowed),
    .dllCmdAllowed(dllCmdAllowed), .zqBusy(zqBusy), .driverCode(driverCode), .dramInReset(dramInReset));

  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? inPowerDown : (s == 1) ? zqBusy : cmdAllowed;
  endfunction
  // Bounded wait for a status level
  task automatic waitFor(input int s, input logic v, output int k);
    k = 0;
    while (pick(s) !== v && k < 2000) begin
      tick();
      k++;
    end
    if (k >= 2000) check("wait bound", 1'b0, 1'b1);
  endtask
  task automatic note(input logic [5:0] f);
    expQ.push_back('{f, codeExp});
  endtask
  // Calibration with all banks closed first
  task automatic zq(input logic lng, input int win);
    int k;
    ctrl_u.issue(sdpz_pkg::CMD_PRE, 1'b1, 3'h0);
    tick(); // No self-refresh exit precedes calibration here
    zqResult = 8'($urandom());
    note(6'b001111);
    codeExp = zqResult;
    note(6'b001110);
    ctrl_u.issue(sdpz_pkg::CMD_ZQ, lng, 3'h0);
    waitFor(1, 1'b0, k); // Nothing else until the window closes
    tick();
    check("calibration window", 16'(zqLast), 16'(win + 1));
  endtask
  // Power-down entry and exit with latency checks
  task automatic pd(input logic sel, input logic [5:0] f, input logic busy);
    int k;
    tick();
    preDllSelect = sel;
    bankBusy = busy;
    note(f);
    note(6'b001110);
    ctrl_u.setCke(1'b0);
    tick();
    if (busy) begin
      check("entry held off", inPowerDown, 1'b0);
      bankBusy = 1'b0;
    end
    waitFor(0, 1'b1, k);
    check("commands in power-down", cmdAllowed, 1'b0);
    ctrl_u.setCke(1'b1); // Short stay, far below nine refresh intervals
    repeat (12) tick();
    check("exit latency", tCmd - tExit >= sdpz_pkg::TXP_CYC, 1'b1);
    if (f[1]) begin
      check("fast exit", 16'(tDll - tCmd), 16'h0000);
    end else begin
      check("slow exit", tDll - tExit >= sdpz_pkg::TXPDLL_CYC, 1'b1);
    end
  endtask

  // Hang guard, calibration length and exit timestamps
  always @(posedge clk) begin
    cycles++;
    if (zqBusy === 1'b1) begin
      zqRun++;
    end else if (zqRun != 0) begin
      zqLast = zqRun;
      zqRun = 0;
    end
    if (prevOut[0] === 1'b1 && inPowerDown === 1'b0) tExit = cycles;
    if (prevOut[1] !== 1'b1 && cmdAllowed === 1'b1) tCmd = cycles;
    if (prevOut[2] !== 1'b1 && dllCmdAllowed === 1'b1) tDll = cycles;
    prevOut = {dllCmdAllowed, cmdAllowed, inPowerDown};
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // Watcher: each state change is matched to the oldest note
  always @(inPowerDown or zqBusy) begin
    if (reset_n === 1'b1) begin
      repeat (2) @(posedge clk);
      #1;
      if (expQ.size() == 0) begin
        check("spare event", 1'b1, 1'b0);
      end else begin
        got = expQ.pop_front();
        check("flags", {inPowerDown, activePd, bufEnable, cmdRxEnable, dllEnable, zqBusy}, got.flags);
        check("driverCode", driverCode, got.code);
      end
    end
  end

  // ****
  // Main sequence
  // ****
  initial begin
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    zqRun = 0;
    zqLast = 0;
    codeExp = 8'h00;
    prevOut = 3'h0;
    reset_n = 1'b0;
    bankBusy = 1'b0;
    dllLocked = 1'b1; // Locked at every entry, so no DLL reset after exit
    preDllSelect = 1'b0;
    zqResult = 8'h00;
    void'($urandom(97265));
    repeat (8) @(posedge clk);
    #1;
    check("reset state", {dramInReset, bufEnable, cmdRxEnable, dllEnable, inPowerDown, zqBusy}, 6'b111100);
    reset_n = 1'b1;
    waitFor(2, 1'b1, n);
    zq(1'b1, sdpz_pkg::TZQINIT_CYC);
    zq(1'b1, sdpz_pkg::TZQOPER_CYC);
    zq(1'b0, sdpz_pkg::TZQCS_CYC);
    pd(1'b1, 6'b100010, 1'b1);
    // Refresh between exit and the next entry, well after tXPDLL
    ctrl_u.issue(sdpz_pkg::CMD_REF, 1'b0, 3'h0);
    pd(1'b0, 6'b100000, 1'b0);
    ctrl_u.issue(sdpz_pkg::CMD_ACT, 1'b0, 3'($urandom()));
    pd(1'b0, 6'b110010, 1'b0);
    // DLL lock loss blocks DLL-dependent commands only
    dllLocked = 1'b0;
    repeat (2) tick();
    check("dllCmdAllowed unlocked", dllCmdAllowed, 1'b0);
    check("cmdAllowed unlocked", cmdAllowed, 1'b1);
    dllLocked = 1'b1;
    repeat (2) tick();
    check("dllCmdAllowed locked", dllCmdAllowed, 1'b1);
    ctrl_u.issue(sdpz_pkg::CMD_PRE, 1'b1, 3'h0);
    // Reset pin pulled low during power-down
    note(6'b100000);
    note(6'b001110);
    ctrl_u.setCke(1'b0);
    waitFor(0, 1'b1, n);
    ctrl_u.setReset(1'b0);
    waitFor(0, 1'b0, n);
    check("reset state entered", dramInReset, 1'b1);
    ctrl_u.setCke(1'b1);
    ctrl_u.setReset(1'b1);
    waitFor(2, 1'b1, n);
    check("reset state left", dramInReset, 1'b0);
    zq(1'b1, sdpz_pkg::TZQINIT_CYC);
    repeat (8) tick();
    check("pending notes", 16'(expQ.size()), 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
